/* hdl/fsrw_defines.vh */
// Constants of the flash status register and write-status logic.
// Assumes inclusion by bare name from each design file of this block.
`ifndef FSRW_DEFINES_VH
`define FSRW_DEFINES_VH

// Command opcodes
`define FSRW_OP_WRITE_STATUS 8'h01
`define FSRW_OP_READ_STATUS  8'h05

// Status byte field positions
`define FSRW_BIT_LOCK  7
`define FSRW_BIT_SEQ   6
`define FSRW_BIT_ERR   5
`define FSRW_BIT_WPP   4
`define FSRW_SWP_HI    3
`define FSRW_SWP_LO    2
`define FSRW_BIT_WEL   1
`define FSRW_BIT_BUSY  0

// Write-status data byte fields
`define FSRW_WD_LOCK   7
`define FSRW_WD_GLO_HI 5
`define FSRW_WD_GLO_LO 2

// Protection summary codes
`define FSRW_SWP_NONE  2'h0
`define FSRW_SWP_SOME  2'h1
`define FSRW_SWP_ALL   2'h3

// Reset values
`define FSRW_RST_LOCK  1'b0
`define FSRW_RST_WEL   1'b0
`define FSRW_RST_SEQ   1'b0
`define FSRW_RST_ERR   1'b0

// Serial framing
`define FSRW_BITS_LAST 3'h7
`define FSRW_BYTE_OPC  2'h0
`define FSRW_BYTE_DAT  2'h1
`define FSRW_BYTE_MORE 2'h2

`endif

/* hdl/fsrw_spi_rx.v */
// Serial receiver: samples SI on SCK rising edges inside a selection.
// Assumes CS, SCK and SI are synchronous to clock and SCK is slower.
`timescale 1ns/100ps
`include "fsrw_defines.vh"

module fsrw_spi_rx (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_sync_b,
  // Serial pins
  input  wire       cs_b,
  input  wire       sck,
  input  wire       si,
  // Received bytes
  output reg        byte_valid,
  output reg  [7:0] rx_byte,
  output reg  [1:0] byte_num,
  // Frame events
  output reg        frame_end,
  output reg        sck_fall
);

  reg       sck_q;
  reg       cs_q;
  reg [6:0] shreg;
  reg [2:0] bit_cnt;

  wire sck_rise = sck & ~sck_q & ~cs_b;

  // Edge detect, shift and byte count; counters cleared outside selection
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sck_q      <= 1'b0;
      cs_q       <= 1'b1;
      shreg      <= 7'h00;
      bit_cnt    <= 3'h0;
      byte_num   <= `FSRW_BYTE_OPC;
      byte_valid <= 1'b0;
      rx_byte    <= 8'h00;
      frame_end  <= 1'b0;
      sck_fall   <= 1'b0;
    end else begin
      sck_q      <= sck;
      cs_q       <= cs_b;
      byte_valid <= 1'b0;
      frame_end  <= cs_b & ~cs_q;
      sck_fall   <= ~sck & sck_q & ~cs_b;
      if (byte_valid && byte_num != `FSRW_BYTE_MORE) begin
        byte_num <= byte_num + 2'h1; // Saturates: later bytes are ignored
      end
      if (cs_b) begin
        bit_cnt  <= 3'h0;
        byte_num <= `FSRW_BYTE_OPC;
      end else if (sck_rise) begin
        shreg   <= {shreg[5:0], si};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == `FSRW_BITS_LAST) begin
          byte_valid <= 1'b1;
          rx_byte    <= {shreg, si};
        end
      end
    end
  end

endmodule // fsrw_spi_rx

/* hdl/fsrw_stat_tx.v */
// Status transmitter: shifts the status byte out on SO, MSB first.
// Assumes SO changes after SCK falling edges (modes 0 and 3).
`timescale 1ns/100ps
`include "fsrw_defines.vh"

module fsrw_stat_tx (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_sync_b,
  // Control
  input  wire       cs_b,
  input  wire       sck_fall,
  input  wire       start,
  input  wire [7:0] status,
  // Serial output
  output reg        so,
  output reg        so_oe_b
);

  reg       pending;
  reg       active;
  reg [6:0] shreg;
  reg [2:0] bit_cnt;

  // Reload a fresh status byte every eight bits while selected
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pending <= 1'b0;
      active  <= 1'b0;
      shreg   <= 7'h00;
      bit_cnt <= 3'h0;
      so      <= 1'b0;
      so_oe_b <= 1'b1;
    end else if (cs_b) begin
      pending <= 1'b0;
      active  <= 1'b0;
      so_oe_b <= 1'b1; // Released outside a selection
    end else begin
      if (start) begin
        pending <= 1'b1;
      end
      if (sck_fall && (pending || active)) begin
        pending <= 1'b0;
        active  <= 1'b1;
        so_oe_b <= 1'b0;
        bit_cnt <= bit_cnt + 3'h1;
        if (!active || bit_cnt == `FSRW_BITS_LAST) begin
          so      <= status[7];
          shreg   <= status[6:0];
          bit_cnt <= 3'h0;
        end else begin
          so      <= shreg[6];
          shreg   <= {shreg[5:0], 1'b0};
        end
      end
    end
  end

endmodule // fsrw_stat_tx

/* hdl/fsrw_top.v */
// Status register and write-status command logic of a serial flash.
// Assumes serial pins synchronous to clock; sector registers, program
// and erase engines and other command decode sit outside this block.
`timescale 1ns/100ps
`include "fsrw_defines.vh"

module fsrw_top #(
  parameter SECTORS = 8
) (
  // Clock and reset
  input  wire               clock,
  input  wire               rst_b,
  // Serial pins
  input  wire               cs_b,
  input  wire               sck,
  input  wire               si,
  output wire               so,
  output wire               so_oe_b,
  // Write-protect pin, low when asserted
  input  wire               wp_b,
  // Engine and decoder events
  input  wire               wren_done,
  input  wire               wrdi_done,
  input  wire               op_end,
  input  wire               op_result_valid,
  input  wire               op_result_fail,
  input  wire               seq_mode_in,
  input  wire               busy_in,
  input  wire [SECTORS-1:0] sector_prot,
  // Protection control
  output reg                protect_regs_lock,
  output reg                write_enable_latch,
  output reg                sector_cmd_allow,
  output reg                global_op_req,
  output reg  [3:0]         global_op_code
);

  reg        rst_meta_b;
  reg        rst_sync_b;
  reg        seq_program_flag;
  reg        erase_program_error;
  reg        write_protect_pin_state;
  reg  [1:0] soft_protect_summary;
  reg        busy_flag;
  reg        wrsr_armed;
  reg        data_full;
  reg  [7:0] wr_data;
  reg        next_lock;
  reg        next_wel;
  reg        next_glob;

  wire       byte_valid;
  wire [7:0] rx_byte;
  wire [1:0] byte_num;
  wire       frame_end;
  wire       sck_fall;
  wire [7:0] device_status;
  wire       rdsr_start;

  // Summary of the sector protection registers
  function [1:0] swp_encode;
    input [SECTORS-1:0] prot;
    begin
      if (&prot) begin
        swp_encode = `FSRW_SWP_ALL;
      end else if (|prot) begin
        swp_encode = `FSRW_SWP_SOME;
      end else begin
        swp_encode = `FSRW_SWP_NONE;
      end
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Byte receiver
  fsrw_spi_rx fsrw_spi_rx_inst (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .cs_b       (cs_b),
    .sck        (sck),
    .si         (si),
    .byte_valid (byte_valid),
    .rx_byte    (rx_byte),
    .byte_num   (byte_num),
    .frame_end  (frame_end),
    .sck_fall   (sck_fall)
  );

  // Status byte assembly
  assign device_status[`FSRW_BIT_LOCK]            = protect_regs_lock;
  assign device_status[`FSRW_BIT_SEQ]             = seq_program_flag;
  assign device_status[`FSRW_BIT_ERR]             = erase_program_error;
  assign device_status[`FSRW_BIT_WPP]             = write_protect_pin_state;
  assign device_status[`FSRW_SWP_HI:`FSRW_SWP_LO] = soft_protect_summary;
  assign device_status[`FSRW_BIT_WEL]             = write_enable_latch;
  assign device_status[`FSRW_BIT_BUSY]            = busy_flag;

  assign rdsr_start = byte_valid && byte_num == `FSRW_BYTE_OPC
                      && rx_byte == `FSRW_OP_READ_STATUS;

  // Status transmitter
  fsrw_stat_tx fsrw_stat_tx_inst (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .cs_b       (cs_b),
    .sck_fall   (sck_fall),
    .start      (rdsr_start),
    .status     (device_status),
    .so         (so),
    .so_oe_b    (so_oe_b)
  );

  // Read-only status fields follow internal logic and the write-protect pin
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      seq_program_flag        <= `FSRW_RST_SEQ;
      erase_program_error     <= `FSRW_RST_ERR;
      write_protect_pin_state <= 1'b0;
      soft_protect_summary    <= `FSRW_SWP_NONE;
      busy_flag               <= 1'b0;
    end else begin
      seq_program_flag        <= seq_mode_in;
      write_protect_pin_state <= wp_b;
      soft_protect_summary    <= swp_encode(sector_prot);
      busy_flag               <= busy_in;
      if (op_result_valid) begin
        erase_program_error <= op_result_fail;
      end
    end
  end

  // Write-status capture: opcode accepted only with the latch set
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wrsr_armed <= 1'b0;
      data_full  <= 1'b0;
      wr_data    <= 8'h00;
    end else if (frame_end) begin
      wrsr_armed <= 1'b0;
      data_full  <= 1'b0;
    end else if (byte_valid) begin
      if (byte_num == `FSRW_BYTE_OPC) begin
        wrsr_armed <= rx_byte == `FSRW_OP_WRITE_STATUS
                      && write_enable_latch;
      end else if (byte_num == `FSRW_BYTE_DAT && wrsr_armed) begin
        wr_data   <= rx_byte;
        data_full <= 1'b1;
      end
    end
  end

  // Next lock and global request at frame end; next latch also on enable, disable and op end
  always @* begin
    next_lock = protect_regs_lock;
    next_wel  = write_enable_latch;
    next_glob = 1'b0;
    if (frame_end && wrsr_armed) begin
      next_wel = 1'b0;
      if (data_full) begin
        if (!wp_b && protect_regs_lock && !wr_data[`FSRW_WD_LOCK]) begin
          next_lock = protect_regs_lock;
        end else begin
          next_lock = wr_data[`FSRW_WD_LOCK];
          next_glob = ~protect_regs_lock;
        end
      end
    end
    if (op_end || wrdi_done) begin
      next_wel = 1'b0;
    end
    if (wren_done) begin
      next_wel = 1'b1;
    end
  end

  // Lock, latch and derived protection outputs
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      protect_regs_lock  <= `FSRW_RST_LOCK;
      write_enable_latch <= `FSRW_RST_WEL;
      sector_cmd_allow   <= 1'b0;
      global_op_req      <= 1'b0;
      global_op_code     <= 4'h0;
    end else begin
      protect_regs_lock  <= next_lock;
      write_enable_latch <= next_wel;
      sector_cmd_allow   <= ~next_lock & next_wel;
      global_op_req      <= next_glob;
      if (next_glob) begin
        global_op_code <= wr_data[`FSRW_WD_GLO_HI:`FSRW_WD_GLO_LO];
      end
    end
  end

endmodule // fsrw_top

/* dv/fsrw_host_model.sv */
// Serial host model: mode 0 frames on cs_b, sck and si, captures so.
// Assumes the device clock; pins change on its falling edges.
`timescale 1ns/100ps
module fsrw_host_model (
  // Clock
  input  wire clock,
  // Serial pins
  output reg  cs_b,
  output reg  sck,
  output reg  si,
  input  wire so,
  input  wire so_oe_b
);
  integer i;
  // Idle: deselected, serial clock still
  initial begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // One selection of n bits from d[23] down; rd keeps the last 16 so bits
  task frame(input [23:0] d, input integer n, output [15:0] rd);
    begin
      rd = 16'h0;
      @(negedge clock);
      cs_b = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge clock);
        si  = d[23-i];
        sck = 1'b0;
        repeat (4) @(negedge clock);
        rd  = {rd[14:0], so_oe_b ? 1'bx : so};
        sck = 1'b1;
        repeat (2) @(negedge clock);
      end
      sck = 1'b0;
      si  = ~si;
      repeat (2) @(negedge clock);
      cs_b = 1'b1;
      repeat (3) @(negedge clock);
    end
  endtask
endmodule // fsrw_host_model

/* dv/fsrw_top_assertions.sv */
// Checker of the status and write-status logic at the top ports.
// Assumes binding into fsrw_top; one clock domain.
`timescale 1ns/100ps
module fsrw_top_assertions (
  // Clock and reset
  input wire       clock,
  input wire       rst_b,
  // Pins and events
  input wire       cs_b,
  input wire       so_oe_b,
  input wire       wp_b,
  input wire       wren_done,
  input wire       wrdi_done,
  input wire       op_end,
  // Protection outputs
  input wire       protect_regs_lock,
  input wire       write_enable_latch,
  input wire       sector_cmd_allow,
  input wire       global_op_req,
  input wire [3:0] global_op_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_ALLOW: assert property ($stable(protect_regs_lock) && $stable(write_enable_latch)
    |-> sector_cmd_allow == (!protect_regs_lock && write_enable_latch)) else $error("allow");
  AST_GLB_LOCK: assert property (global_op_req |-> !$past(protect_regs_lock))
    else $error("global while locked");
  AST_GLB_PULSE: assert property (global_op_req |=> !global_op_req)
    else $error("global pulse long");
  AST_GLB_WEL: assert property (global_op_req && !$past(wren_done)
    |-> !write_enable_latch) else $error("latch kept");
  AST_CODE: assert property (!global_op_req |-> $stable(global_op_code))
    else $error("code moved");
  AST_WEL_SET: assert property ($rose(write_enable_latch) |-> $past(wren_done))
    else $error("latch set");
  AST_WEL_WREN: assert property (wren_done |=> write_enable_latch)
    else $error("latch not set");
  AST_WEL_CLR: assert property ((wrdi_done || op_end) && !wren_done
    |=> !write_enable_latch) else $error("latch not cleared");
  AST_LOCK_CS: assert property ($changed(protect_regs_lock)
    |-> $past(cs_b) && $past(cs_b, 2)) else $error("lock moved in frame");
  AST_LOCK_WP: assert property ($fell(protect_regs_lock) |-> $past(wp_b))
    else $error("lock cleared with pin");
  AST_SO_OFF: assert property (cs_b ##1 cs_b |-> so_oe_b)
    else $error("so driven");
  cover property (global_op_req);
  cover property ($fell(protect_regs_lock));
  cover property (wren_done ##1 write_enable_latch);
endmodule // fsrw_top_assertions
bind fsrw_top fsrw_top_assertions fsrw_top_assertions_inst (.clock, .rst_b, .cs_b,
  .so_oe_b, .wp_b, .wren_done, .wrdi_done, .op_end, .protect_regs_lock,
  .write_enable_latch, .sector_cmd_allow, .global_op_req, .global_op_code);

/* dv/tb_fsrw_top.sv */
// Testbench of fsrw_top: status reads and write-status frames.
// Assumes the host model drives the serial pins.
`timescale 1ns/100ps
module tb_fsrw_top;
  reg         clock, rst_b, wp_b, op_result_fail, seq_mode_in, busy_in;
  reg         wren_done, wrdi_done, op_end, op_result_valid;
  reg  [7:0]  sector_prot;
  wire        cs_b, sck, si, so, so_oe_b, protect_regs_lock, write_enable_latch;
  wire        sector_cmd_allow, global_op_req;
  wire [3:0]  global_op_code;
  reg  [15:0] rd;
  reg         lock_e, wel_e, err_e;
  integer     fails, cmp_count, greq_n, k;
  fsrw_top #(.SECTORS(8)) fsrw_top_inst (.clock, .rst_b, .cs_b, .sck, .si, .so,
    .so_oe_b, .wp_b, .wren_done, .wrdi_done, .op_end, .op_result_valid,
    .op_result_fail, .seq_mode_in, .busy_in, .sector_prot, .protect_regs_lock,
    .write_enable_latch, .sector_cmd_allow, .global_op_req, .global_op_code);
  fsrw_host_model fsrw_host_model_inst (.clock, .cs_b, .sck, .si, .so, .so_oe_b);
  // Clock and global request count
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  // Sampled on the falling edge, where the registered pulse has settled
  always @(negedge clock) if (global_op_req === 1'b1) greq_n = greq_n + 1;
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  function [7:0] stat_e();
    stat_e = {lock_e, seq_mode_in, err_e, wp_b, ~|sector_prot ? 2'h0 :
      &sector_prot ? 2'h3 : 2'h1, wel_e, busy_in};
  endfunction
  // Event pulse: 0 enable, 1 disable, 2 op end, 3 result
  task pulse(input [1:0] p);
    begin
      @(negedge clock);
      {op_result_valid, op_end, wrdi_done, wren_done} = 4'h1 << p;
      @(negedge clock);
      {op_result_valid, op_end, wrdi_done, wren_done} = 4'h0;
      repeat (2) @(negedge clock);
    end
  endtask
  task rd_stat;
    begin
      fsrw_host_model_inst.frame({8'h05, 16'h0}, 24, rd);
      check("status 1", rd[15:8], stat_e());
      check("status 2", rd[7:0], stat_e());
      check("lock", protect_regs_lock, lock_e);
      check("latch", write_enable_latch, wel_e);
      check("allow", sector_cmd_allow, ~lock_e & wel_e);
    end
  endtask
  task wrsr(input [23:0] d, input integer n, input integer g);
    integer g0;
    begin
      g0 = greq_n;
      fsrw_host_model_inst.frame(d, n, rd);
      check("globals", greq_n - g0, g);
      rd_stat;
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    fails = fails + 1;
    stop_test;
  end
  // Main sequence
  initial begin
    {fails, cmp_count, greq_n, lock_e, wel_e, err_e} = 0;
    {rst_b, op_result_fail, seq_mode_in, busy_in, sector_prot} = 0;
    {op_result_valid, op_end, wrdi_done, wren_done} = 4'h0;
    wp_b = 1'b0;
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    rd_stat;
    wrsr(24'h01ff00, 16, 0);
    pulse(0);
    {lock_e, wel_e} = 2'b10;
    wrsr(24'h01ff00, 16, 1);
    check("code", global_op_code, 4'hf);
    pulse(0);
    wrsr(24'h015800, 16, 0);
    wp_b = 1'b1;
    pulse(0);
    lock_e = 1'b0;
    wrsr(24'h0124ff, 24, 0);
    check("code", global_op_code, 4'hf);
    pulse(0);
    wrsr(24'h01a000, 12, 0);
    pulse(0);
    wel_e = 1'b1;
    wrsr(24'h000000, 4, 0);
    pulse(1);
    wel_e = 1'b0;
    rd_stat;
    op_result_fail = 1'b1;
    pulse(0);
    pulse(3);
    pulse(2);
    err_e = 1'b1;
    rd_stat;
    op_result_fail = 1'b0;
    pulse(3);
    err_e = 1'b0;
    rd_stat;
    for (k = 0; k < 4; k = k + 1) begin
      sector_prot = k[1] ? 8'hff : (k[0] ? 8'h24 : 8'h00);
      {seq_mode_in, busy_in, wp_b} = {k[0], k[1], k[0]};
      rd_stat;
    end
    // Host reads status once with the busy flag set, then once after it falls
    busy_in = 1'b1;
    rd_stat;
    busy_in = 1'b0;
    rd_stat;
    pulse(0);
    lock_e = 1'b1;
    wrsr(24'h018000, 16, 1);
    pulse(0);
    rst_b = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    lock_e = 1'b0;
    rd_stat;
    stop_test;
  end
endmodule // tb_fsrw_top
